// ---- common/pus_pkg.sv ----
// Purpose: shared constants and types of the parallel unit supervisor
// Assumes: 20 MHz system clock, APB register access, 32-bit data
// Notes:   link messages carry a kind, a unit address and 16 data bits
package pus_pkg;
   localparam int          CLK_MHZ       = 20;
   localparam int          POLL_WAIT_US  = 100;
   localparam int          POLL_WAIT_CYC = POLL_WAIT_US * CLK_MHZ;
   localparam int          SUPERVISE_US  = 10000;
   localparam int          SUPERVISE_CYC = SUPERVISE_US * CLK_MHZ;
   localparam int          TMR_W         = 18;

   // unit addresses: 0 is the master, 1..15 the slave positions
   localparam logic [3:0]  ADDR_MASTER   = 4'h0;
   localparam logic [3:0]  FIRST_SLAVE   = 4'h1;
   localparam logic [3:0]  MAX_SLAVES    = 4'hF;

   // register byte offsets
   localparam logic [11:0] ADDR_CTRL     = 12'h000;
   localparam logic [11:0] ADDR_STATUS   = 12'h004;
   localparam logic [11:0] ADDR_SETVAL   = 12'h008;
   localparam logic [11:0] ADDR_RATE_I   = 12'h00C;
   localparam logic [11:0] ADDR_RATE_P   = 12'h010;
   localparam logic [11:0] ADDR_RATE_R   = 12'h014;
   localparam logic [11:0] ADDR_TOTAL_I  = 12'h018;
   localparam logic [11:0] ADDR_TOTAL_P  = 12'h01C;
   localparam logic [11:0] ADDR_TOTAL_R  = 12'h020;
   localparam logic [11:0] ADDR_ALARM    = 12'h024;
   localparam logic [11:0] ADDR_THR_V    = 12'h028;
   localparam logic [11:0] ADDR_THR_I    = 12'h02C;
   localparam logic [11:0] ADDR_THR_P    = 12'h030;

   // control register fields
   localparam int          CTRL_MODE_LSB = 0;
   localparam int          CTRL_REINIT   = 2;
   localparam int          CTRL_OUT_ON   = 3;
   localparam int          CTRL_ACK      = 4;
   localparam int          CTRL_ADDR_LSB = 8;

   // parallel_unit_mode codes
   localparam logic [1:0]  MODE_OFF      = 2'h0;
   localparam logic [1:0]  MODE_SLAVE    = 2'h1;
   localparam logic [1:0]  MODE_MASTER   = 2'h2;

   // link message kinds
   localparam logic [1:0]  K_POLL        = 2'h0;
   localparam logic [1:0]  K_ANSWER      = 2'h1;
   localparam logic [1:0]  K_SETVAL      = 2'h2;
   localparam logic [1:0]  K_ACK         = 2'h3;
   localparam int          SETVAL_OUT    = 15;

   // alarm vector bits
   localparam int          ALM_OV        = 0;
   localparam int          ALM_OC        = 1;
   localparam int          ALM_OP        = 2;
   localparam int          ALM_PF        = 3;
   localparam int          ALM_OT        = 4;
   localparam int          ALM_W         = 5;
   localparam logic [4:0]  ALM_AUTO      = 5'h18;

   localparam logic [15:0] THR_RST       = 16'hFFFF;
   localparam logic [15:0] RATE_RST      = 16'h0001;

   typedef struct packed {
      logic        valid;
      logic [1:0]  kind;
      logic [3:0]  addr;
      logic [15:0] data;
   } pus_msg_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } pus_apb_req_t;

   typedef enum logic [2:0] {
      ST_IDLE, ST_POLL, ST_WAIT, ST_CALC, ST_RUN, ST_FAIL, ST_SLAVE
   } pus_state_t;

   typedef struct packed {
      pus_state_t  state;
      logic        first;
      logic [1:0]  mode;
      logic [3:0]  addr;
      logic        searching;
      logic [3:0]  pos;
      logic [15:0] found;
      logic [3:0]  count;
      logic [TMR_W-1:0] tmr;
      logic [15:0] setval;
      logic        out_on;
      logic        dc_on;
      logic        auto_rst;
      logic [15:0] thr_v;
      logic [15:0] thr_i;
      logic [15:0] thr_p;
      logic [15:0] rate_i;
      logic [15:0] rate_p;
      logic [15:0] rate_r;
      logic [20:0] tot_i;
      logic [20:0] tot_p;
      logic [15:0] tot_r;
      logic [15:0] rem;
      logic        link_alm;
      logic        init_fail;
      logic        ctl;
      logic        hold;
      logic [4:0]  alm_code;
      logic [3:0]  alm_src;
      logic        alm_new;
      logic        ack_pend;
      logic [4:0]  last_alm;
      pus_msg_t    tx;
      logic [31:0] prdata;
      logic        pslverr;
   } pus_regs_t;
endpackage : pus_pkg

// ---- rtl/pus_supervisor.sv ----
// Purpose: supervisor of one supply unit in a master/slave parallel system
// Assumes: synchronous inputs, one message per cycle on the unit link
// Notes:   registers over APB, zero wait states
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ps
module pus_supervisor #(
   parameter int SUPERVISE_CYCLES = pus_pkg::SUPERVISE_CYC
) (
   input  wire logic             REF_CLK,
   input  wire logic             RST,
   input  wire logic             PSEL,
   input  wire logic             PENABLE,
   input  wire logic             PWRITE,
   input  wire logic [11:0]      PADDR,
   input  wire logic [31:0]      PWDATA,
   output logic      [31:0]      PRDATA,
   output logic                  PREADY,
   output logic                  PSLVERR,
   input  wire logic [1:0]       CFG_MODE,
   input  wire logic [15:0]      MEAS_V,
   input  wire logic [15:0]      MEAS_I,
   input  wire logic [15:0]      MEAS_P,
   input  wire logic             POWER_FAIL_ALARM,
   input  wire logic             OVERTEMPERATURE_ALARM,
   input  wire logic             OUTPUT_INHIBIT_INPUT,
   input  wire pus_pkg::pus_msg_t LINK_RX,
   output pus_pkg::pus_msg_t     LINK_TX,
   output logic                  OUTPUT_ENABLE,
   output logic                  LINK_PROTECTION_ALARM,
   output logic                  CONTROL_LOCK,
   output logic      [15:0]      SET_VALUE
);
   localparam int TMR_W_L = pus_pkg::TMR_W;
   localparam logic [TMR_W_L-1:0] SUP_LAST = TMR_W_L'(SUPERVISE_CYCLES - 1);
   localparam logic [TMR_W_L-1:0] POLL_LAST = TMR_W_L'(pus_pkg::POLL_WAIT_CYC - 1);

   pus_pkg::pus_regs_t r_reg;
   pus_pkg::pus_regs_t r_next;
   pus_pkg::pus_apb_req_t apb;

   logic [4:0]  alarms;
   logic [4:0]  new_alm;
   logic [4:0]  units;
   logic [31:0] rd_val;
   logic        hit;
   logic        wr;
   logic        start;
   logic        adv;
   logic        rx_mine;

   assign apb = '{PSEL, PENABLE, PWRITE, PADDR, PWDATA};

   // own threshold supervision plus sensor alarms
   always_comb begin
      alarms = '0;
      alarms[pus_pkg::ALM_OV] = MEAS_V > r_reg.thr_v;
      alarms[pus_pkg::ALM_OC] = MEAS_I > r_reg.thr_i;
      alarms[pus_pkg::ALM_OP] = MEAS_P > r_reg.thr_p;
      alarms[pus_pkg::ALM_PF] = POWER_FAIL_ALARM;
      alarms[pus_pkg::ALM_OT] = OVERTEMPERATURE_ALARM;
   end

   // read decode
   always_comb begin
      hit    = 1'b1;
      rd_val = '0;
      if (apb.paddr == pus_pkg::ADDR_CTRL) begin
         rd_val = {20'h00000, r_reg.addr, 3'h0, 1'b0, r_reg.out_on, 1'b0, r_reg.mode};
      end else if (apb.paddr == pus_pkg::ADDR_STATUS) begin
         rd_val = {17'h00000, r_reg.state, r_reg.mode, r_reg.alm_new, r_reg.hold,
                   r_reg.dc_on, r_reg.ctl, r_reg.init_fail, r_reg.link_alm,
                   r_reg.count};
      end else if (apb.paddr == pus_pkg::ADDR_SETVAL) begin
         rd_val = {16'h0000, r_reg.setval};
      end else if (apb.paddr == pus_pkg::ADDR_RATE_I) begin
         rd_val = {16'h0000, r_reg.rate_i};
      end else if (apb.paddr == pus_pkg::ADDR_RATE_P) begin
         rd_val = {16'h0000, r_reg.rate_p};
      end else if (apb.paddr == pus_pkg::ADDR_RATE_R) begin
         rd_val = {16'h0000, r_reg.rate_r};
      end else if (apb.paddr == pus_pkg::ADDR_TOTAL_I) begin
         rd_val = {11'h000, r_reg.tot_i};
      end else if (apb.paddr == pus_pkg::ADDR_TOTAL_P) begin
         rd_val = {11'h000, r_reg.tot_p};
      end else if (apb.paddr == pus_pkg::ADDR_TOTAL_R) begin
         rd_val = {16'h0000, r_reg.tot_r};
      end else if (apb.paddr == pus_pkg::ADDR_ALARM) begin
         rd_val = {11'h000, alarms, 4'h0, r_reg.alm_src, 3'h0, r_reg.alm_code};
      end else if (apb.paddr == pus_pkg::ADDR_THR_V) begin
         rd_val = {16'h0000, r_reg.thr_v};
      end else if (apb.paddr == pus_pkg::ADDR_THR_I) begin
         rd_val = {16'h0000, r_reg.thr_i};
      end else if (apb.paddr == pus_pkg::ADDR_THR_P) begin
         rd_val = {16'h0000, r_reg.thr_p};
      end else begin
         hit = 1'b0;
      end
   end

   always_comb begin
      r_next         = r_reg;
      r_next.tx      = '0;
      r_next.first   = 1'b0;
      r_next.last_alm = alarms;
      new_alm        = alarms & ~r_reg.last_alm;
      units          = {1'b0, r_reg.count} + 5'h01;
      wr             = apb.psel & apb.penable & apb.pwrite & ~r_reg.pslverr;
      start          = 1'b0;
      adv            = 1'b0;
      rx_mine        = LINK_RX.valid && LINK_RX.addr == r_reg.addr;

      // apb setup phase: capture answer for the access phase
      if (apb.psel && !apb.penable) begin
         r_next.prdata  = hit ? rd_val : 32'h00000000;
         r_next.pslverr = ~hit;
         if (apb.pwrite && r_reg.ctl && apb.paddr != pus_pkg::ADDR_CTRL) begin
            r_next.pslverr = 1'b1;
         end
      end

      // register writes
      if (wr) begin
         if (apb.paddr == pus_pkg::ADDR_CTRL) begin
            r_next.addr = apb.pwdata[pus_pkg::CTRL_ADDR_LSB +: 4];
            r_next.mode = apb.pwdata[pus_pkg::CTRL_MODE_LSB +: 2];
            if (!r_reg.ctl) begin
               r_next.out_on = apb.pwdata[pus_pkg::CTRL_OUT_ON] && alarms == '0;
               r_next.auto_rst = 1'b0;
               if (apb.pwdata[pus_pkg::CTRL_ACK] && r_reg.alm_new) begin
                  r_next.alm_new  = 1'b0;
                  r_next.ack_pend = 1'b1;
               end
               if (apb.pwdata[pus_pkg::CTRL_REINIT] && r_next.mode == pus_pkg::MODE_MASTER) begin
                  start = 1'b1;
               end
            end
            if (r_next.mode != r_reg.mode) begin
               r_next.ctl      = 1'b0;
               r_next.out_on   = 1'b0;
               r_next.link_alm = r_next.mode == pus_pkg::MODE_SLAVE;
               r_next.state    = r_next.mode == pus_pkg::MODE_SLAVE ?
                                 pus_pkg::ST_SLAVE : pus_pkg::ST_IDLE;
               start           = r_next.mode == pus_pkg::MODE_MASTER;
            end
         end else if (apb.paddr == pus_pkg::ADDR_SETVAL) begin
            // clamp to the scaled system current range
            r_next.setval = {5'h00, apb.pwdata[15:0]} > r_reg.tot_i ?
                            r_reg.tot_i[15:0] : apb.pwdata[15:0];
         end else if (apb.paddr == pus_pkg::ADDR_RATE_I) begin
            r_next.rate_i = apb.pwdata[15:0];
         end else if (apb.paddr == pus_pkg::ADDR_RATE_P) begin
            r_next.rate_p = apb.pwdata[15:0];
         end else if (apb.paddr == pus_pkg::ADDR_RATE_R) begin
            r_next.rate_r = apb.pwdata[15:0];
         end else if (apb.paddr == pus_pkg::ADDR_THR_V) begin
            r_next.thr_v = apb.pwdata[15:0];
         end else if (apb.paddr == pus_pkg::ADDR_THR_I) begin
            r_next.thr_i = apb.pwdata[15:0];
         end else if (apb.paddr == pus_pkg::ADDR_THR_P) begin
            r_next.thr_p = apb.pwdata[15:0];
         end
      end

      // power-up: take the stored mode
      if (r_reg.first) begin
         r_next.mode = CFG_MODE;
         if (CFG_MODE == pus_pkg::MODE_MASTER) begin
            start = 1'b1;
         end else if (CFG_MODE == pus_pkg::MODE_SLAVE) begin
            r_next.state    = pus_pkg::ST_SLAVE;
            r_next.link_alm = 1'b1;
         end
      end

      case (r_reg.state)
         pus_pkg::ST_POLL: begin
            r_next.tmr = '0;
            if (!r_reg.searching && !r_reg.found[r_reg.pos]) begin
               adv = 1'b1;
            end else begin
               r_next.tx    = '{1'b1, pus_pkg::K_POLL, r_reg.pos,
                                {15'h0000, r_reg.searching}};
               r_next.state = pus_pkg::ST_WAIT;
            end
         end
         pus_pkg::ST_WAIT: begin
            r_next.tmr = r_reg.tmr + 1'b1;
            if (LINK_RX.valid && LINK_RX.kind == pus_pkg::K_ANSWER &&
                LINK_RX.addr == r_reg.pos) begin
               adv = 1'b1;
               if (r_reg.searching) begin
                  r_next.found[r_reg.pos] = 1'b1;
                  r_next.count = r_reg.count + 1'b1;
               end else if (LINK_RX.data[4:0] != '0) begin
                  r_next.alm_code = LINK_RX.data[4:0];
                  r_next.alm_src  = r_reg.pos;
                  r_next.alm_new  = 1'b1;
               end
            end else if (r_reg.searching && LINK_RX.valid && LINK_RX.kind == pus_pkg::K_POLL) begin
               r_next.init_fail = 1'b1;
               r_next.state     = pus_pkg::ST_FAIL;
            end else if (r_reg.tmr == POLL_LAST) begin
               if (r_reg.searching) begin
                  adv = 1'b1;
               end else begin
                  r_next.link_alm = 1'b1;
                  r_next.out_on   = 1'b0;
                  // off command to all slaves, set value kept
                  r_next.tx       = '{1'b1, pus_pkg::K_SETVAL, pus_pkg::ADDR_MASTER,
                                      {1'b0, r_reg.setval[14:0]}};
                  r_next.state    = pus_pkg::ST_FAIL;
               end
            end
         end
         pus_pkg::ST_CALC: begin
            r_next.tot_i = {5'h00, r_reg.rate_i} * {16'h0000, units};
            r_next.tot_p = {5'h00, r_reg.rate_p} * {16'h0000, units};
            // resistance of units in parallel by repeated subtraction
            if (r_reg.rem >= {11'h000, units}) begin
               r_next.rem   = r_reg.rem - {11'h000, units};
               r_next.tot_r = r_reg.tot_r + 1'b1;
            end else begin
               r_next.searching = 1'b0;
               r_next.setval    = '0;
               r_next.out_on    = 1'b0;
               r_next.link_alm  = 1'b0;
               r_next.state     = pus_pkg::ST_RUN;
            end
         end
         pus_pkg::ST_RUN: begin
            if (r_reg.ack_pend) begin
               r_next.tx       = '{1'b1, pus_pkg::K_ACK, r_reg.alm_src, 16'h0000};
               r_next.ack_pend = 1'b0;
            end else begin
               r_next.tx = '{1'b1, pus_pkg::K_SETVAL, pus_pkg::ADDR_MASTER,
                             {r_reg.out_on, r_reg.setval[14:0]}};
            end
            r_next.pos   = pus_pkg::FIRST_SLAVE;
            r_next.state = pus_pkg::ST_POLL;
         end
         pus_pkg::ST_SLAVE: begin
            r_next.tmr = r_reg.ctl ? r_reg.tmr + 1'b1 : '0;
            if (LINK_RX.valid) begin
               if (rx_mine && LINK_RX.kind == pus_pkg::K_POLL) begin
                  r_next.tmr = '0;
                  r_next.tx  = '{1'b1, pus_pkg::K_ANSWER, r_reg.addr,
                                 {11'h000, r_reg.hold ? r_reg.alm_code : 5'h00}};
                  if (LINK_RX.data[0]) begin
                     r_next.ctl      = 1'b1;
                     r_next.link_alm = 1'b0;
                     r_next.hold     = 1'b0;
                     r_next.out_on   = 1'b0;
                     r_next.thr_v    = pus_pkg::THR_RST;
                     r_next.thr_i    = pus_pkg::THR_RST;
                     r_next.thr_p    = pus_pkg::THR_RST;
                  end
               end else if (r_reg.ctl && LINK_RX.kind == pus_pkg::K_SETVAL) begin
                  r_next.tmr    = '0;
                  r_next.setval = {1'b0, LINK_RX.data[14:0]};
                  r_next.out_on = LINK_RX.data[pus_pkg::SETVAL_OUT] &&
                                  !r_reg.hold && alarms == '0;
               end else if (r_reg.ctl && rx_mine && LINK_RX.kind == pus_pkg::K_ACK) begin
                  r_next.tmr  = '0;
                  r_next.hold = 1'b0;
               end
            end
            if (r_reg.ctl && r_reg.tmr == SUP_LAST) begin
               r_next.ctl      = 1'b0;
               r_next.out_on   = 1'b0;
               r_next.link_alm = 1'b1;
            end
         end
         default: begin
         end
      endcase

      // advance to the next slave position, at most fifteen
      if (adv) begin
         if (r_reg.pos == pus_pkg::MAX_SLAVES) begin
            r_next.state = r_reg.searching ? pus_pkg::ST_CALC : pus_pkg::ST_RUN;
         end else begin
            r_next.pos   = r_reg.pos + 1'b1;
            r_next.state = pus_pkg::ST_POLL;
         end
      end

      if (start) begin
         r_next.state     = pus_pkg::ST_POLL;
         r_next.searching = 1'b1;
         r_next.pos       = pus_pkg::FIRST_SLAVE;
         r_next.found     = '0;
         r_next.count     = '0;
         r_next.ctl       = 1'b0;
         r_next.init_fail = 1'b0;
         // a new init clears link loss at once
         r_next.link_alm  = 1'b0;
         r_next.out_on    = 1'b0;
         r_next.rem       = r_reg.rate_r;
         r_next.tot_r     = '0;
      end

      // own alarms
      if (new_alm != '0) begin
         r_next.out_on   = 1'b0;
         r_next.auto_rst = r_reg.out_on && (new_alm & ~pus_pkg::ALM_AUTO) == '0;
         r_next.alm_code = new_alm;
         r_next.alm_src  = pus_pkg::ADDR_MASTER;
         if (r_reg.ctl) begin
            r_next.hold = 1'b1;
         end else begin
            r_next.alm_new = 1'b1;
         end
      end else if (r_reg.auto_rst && alarms == '0) begin
         r_next.out_on   = 1'b1;
         r_next.auto_rst = 1'b0;
      end

      r_next.dc_on = r_next.out_on && !OUTPUT_INHIBIT_INPUT;
   end

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         r_reg          <= '0;
         r_reg.state    <= pus_pkg::ST_IDLE;
         r_reg.first    <= 1'b1;
         r_reg.pos      <= pus_pkg::FIRST_SLAVE;
         r_reg.thr_v    <= pus_pkg::THR_RST;
         r_reg.thr_i    <= pus_pkg::THR_RST;
         r_reg.thr_p    <= pus_pkg::THR_RST;
         r_reg.rate_i   <= pus_pkg::RATE_RST;
         r_reg.rate_p   <= pus_pkg::RATE_RST;
         r_reg.rate_r   <= pus_pkg::RATE_RST;
      end else begin
         r_reg <= r_next;
      end
   end

   assign PRDATA                = r_reg.prdata;
   assign PREADY                = 1'b1;
   assign PSLVERR               = apb.psel & apb.penable & r_reg.pslverr;
   assign LINK_TX               = r_reg.tx;
   assign OUTPUT_ENABLE         = r_reg.dc_on;
   assign LINK_PROTECTION_ALARM = r_reg.link_alm;
   assign CONTROL_LOCK          = r_reg.ctl;
   assign SET_VALUE             = r_reg.setval;
endmodule : pus_supervisor

// ---- tb/pus_monitor.sv ----
// Purpose: port assertions of the unit supervisor
// Assumes: one clock, RST async active high
// Notes:   bound into pus_supervisor
`timescale 1ns/1ps
module pus_monitor (
   input wire logic              REF_CLK,
   input wire logic              RST,
   input wire logic              PSEL,
   input wire logic              PENABLE,
   input wire logic              PWRITE,
   input wire logic [11:0]       PADDR,
   input wire logic [31:0]       PWDATA,
   input wire logic              PSLVERR,
   input wire logic              POWER_FAIL_ALARM,
   input wire logic              OUTPUT_INHIBIT_INPUT,
   input wire pus_pkg::pus_msg_t LINK_TX,
   input wire logic              OUTPUT_ENABLE,
   input wire logic              LINK_PROTECTION_ALARM,
   input wire logic              CONTROL_LOCK,
   input wire logic [15:0]       SET_VALUE
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (RST);
   sequence acc_s; PSEL && PENABLE; endsequence
   sequence poll_s; LINK_TX.valid && LINK_TX.kind == pus_pkg::K_POLL; endsequence
   sequence bcast_s; LINK_TX.valid && LINK_TX.kind == pus_pkg::K_SETVAL; endsequence
   inhibit_off_a: assert property (OUTPUT_INHIBIT_INPUT |=> !OUTPUT_ENABLE)
      else $error("output on while inhibited");
   alarm_off_a: assert property (POWER_FAIL_ALARM |=> !OUTPUT_ENABLE)
      else $error("output on during alarm");
   link_off_a: assert property (LINK_PROTECTION_ALARM && $past(LINK_PROTECTION_ALARM)
      |-> !OUTPUT_ENABLE) else $error("output on after link loss");
   poll_addr_a: assert property (poll_s |-> LINK_TX.addr != pus_pkg::ADDR_MASTER)
      else $error("poll to master address");
   bcast_value_a: assert property (bcast_s |-> LINK_TX.data[14:0] == SET_VALUE[14:0]
      || LINK_TX.data[14:0] == $past(SET_VALUE[14:0])) else $error("broadcast value");
   unmapped_err_a: assert property (acc_s ##0 PADDR > pus_pkg::ADDR_THR_P |-> PSLVERR)
      else $error("unmapped access accepted");
   lock_reject_a: assert property (acc_s ##0 PWRITE && CONTROL_LOCK
      && PADDR == pus_pkg::ADDR_SETVAL |-> PSLVERR) else $error("locked write taken");
   reinit_clear_a: assert property (acc_s ##0 PWRITE && PADDR == pus_pkg::ADDR_CTRL
      && PWDATA[pus_pkg::CTRL_REINIT]
      && PWDATA[1:0] == pus_pkg::MODE_MASTER && !CONTROL_LOCK |-> ##[1:2] !LINK_PROTECTION_ALARM)
      else $error("link alarm kept after reinit");
endmodule : pus_monitor
bind pus_supervisor pus_monitor mon (.*);

// ---- tb/pus_slave_model.sv ----
// Purpose: one slave unit answering master polls
// Assumes: answers on the edge after a poll
// Notes:   alive low models a cut link
`timescale 1ns/1ps
module pus_slave_model #(
   parameter logic [3:0] ADDR = 4'h1
) (
   input  wire logic              clk,
   input  wire logic              alive,
   input  wire pus_pkg::pus_msg_t tx,
   output pus_pkg::pus_msg_t      rx
);
   initial rx = '0;
   always @(posedge clk) begin
      rx.valid <= 1'b0;
      rx.data  <= ~rx.data;
      if (alive && tx.valid && tx.kind == pus_pkg::K_POLL && tx.addr == ADDR) begin
         rx <= '{1'b1, pus_pkg::K_ANSWER, ADDR, 16'h0000};
      end
   end
endmodule : pus_slave_model

// ---- tb/parallel_unit_supervisor_test.sv ----
// Purpose: self-checking bench of the supervisor as master
// Assumes: one slave model at position 1
// Notes:   most run time is poll waiting
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin fail_count++; \
   $display("MISMATCH %s exp %h got %h", n, e, s); end end
module parallel_unit_supervisor_test;
   logic              clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [11:0]       paddr = 12'h000;
   logic [31:0]       pwdata = 32'h0, prdata;
   logic              pready, pslverr, oe, lpa, lock;
   logic              pf = 1'b0, inh = 1'b0, alive = 1'b1;
   logic [15:0]       mv, mi, mp, sv, r;
   pus_pkg::pus_msg_t rx, tx;
   logic [32:0]       e, exp_q[$];
   int                checks = 0, fail_count = 0, i;
   always #25 clk = ~clk;
   pus_supervisor #(.SUPERVISE_CYCLES(5000)) uut (.REF_CLK(clk), .RST(rst), .PSEL(psel),
      .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .CFG_MODE(pus_pkg::MODE_MASTER), .MEAS_V(mv),
      .MEAS_I(mi), .MEAS_P(mp), .POWER_FAIL_ALARM(pf), .OVERTEMPERATURE_ALARM(1'b0),
      .OUTPUT_INHIBIT_INPUT(inh), .LINK_RX(rx), .LINK_TX(tx), .OUTPUT_ENABLE(oe),
      .LINK_PROTECTION_ALARM(lpa), .CONTROL_LOCK(lock), .SET_VALUE(sv));
   pus_slave_model #(.ADDR(4'h1)) slave (.clk(clk), .alive(alive), .tx(tx), .rx(rx));
   task automatic wrap_up;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : wrap_up
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
         input logic [32:0] x);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      exp_q.push_back(x);
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb
   task automatic wait_bcast;
      for (i = 0; i < 40000 && !(tx.valid && tx.kind == pus_pkg::K_SETVAL); i++) @(negedge clk);
      `CHK("bcast", 1'b1, tx.valid)
   endtask : wait_bcast
   // error flag and read data of each finished transfer
   always @(posedge clk) begin
      if (psel && pen && pready) begin
         e = exp_q.pop_front();
         `CHK("apb", e, {pslverr, pwr ? 32'h0 : prdata})
      end
   end
   initial begin
      void'($urandom(32'h2368));
      {mv, mi, mp} <= 48'({$urandom, $urandom});
      r = 16'($urandom);
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      wait_bcast();
      apb(1'b0, pus_pkg::ADDR_TOTAL_I, 32'h0, 33'h2);
      apb(1'b0, pus_pkg::ADDR_TOTAL_P, 32'h0, 33'h2);
      apb(1'b0, pus_pkg::ADDR_TOTAL_R, 32'h0, 33'h0);
      apb(1'b0, pus_pkg::ADDR_SETVAL, 32'h0, 33'h0);
      apb(1'b0, pus_pkg::ADDR_THR_P, 32'h0, 33'hFFFF);
      apb(1'b0, 12'h040, 32'h0, 33'h1_0000_0000);
      apb(1'b1, pus_pkg::ADDR_SETVAL, {16'h0, r}, 33'h0);
      apb(1'b0, pus_pkg::ADDR_SETVAL, 32'h0, {17'h0, (r > 16'h2) ? 16'h2 : r});
      `CHK("set_value", (r > 16'h2) ? 16'h2 : r, sv)
      `CHK("lock", 1'b0, lock)
      apb(1'b1, pus_pkg::ADDR_CTRL, 32'hA, 33'h0);
      repeat (2) @(negedge clk);
      `CHK("out", 1'b1, oe)
      @(posedge clk) inh <= 1'b1;
      repeat (2) @(negedge clk);
      `CHK("inhibit", 1'b0, oe)
      @(posedge clk) inh <= 1'b0;
      apb(1'b1, pus_pkg::ADDR_THR_V, 32'h8000, 33'h0);
      @(posedge clk) mv <= 16'h8001;
      repeat (3) @(posedge clk);
      apb(1'b0, pus_pkg::ADDR_ALARM, 32'h0, 33'h0001_0001);
      @(negedge clk) `CHK("alarm", 1'b0, oe)
      @(posedge clk) mv <= 16'h0;
      repeat (2) @(negedge clk);
      `CHK("no_auto", 1'b0, oe)
      apb(1'b1, pus_pkg::ADDR_CTRL, 32'h1A, 33'h0);
      @(negedge clk) `CHK("on", 1'b1, oe)
      @(posedge clk) pf <= 1'b1;
      repeat (2) @(posedge clk);
      pf <= 1'b0;
      repeat (2) @(negedge clk);
      `CHK("restore", 1'b1, oe)
      @(posedge clk) alive <= 1'b0;
      for (i = 0; i < 5000 && lpa !== 1'b1; i++) @(negedge clk);
      `CHK("link", 1'b1, lpa)
      `CHK("off", 1'b0, oe)
      apb(1'b1, pus_pkg::ADDR_CTRL, 32'h6, 33'h0);
      repeat (2) @(negedge clk);
      `CHK("clear", 1'b0, lpa)
      wait_bcast();
      apb(1'b0, pus_pkg::ADDR_TOTAL_I, 32'h0, 33'h1);
      wrap_up();
   end
   initial begin
      repeat (90000) @(posedge clk);
      fail_count++;
      wrap_up();
   end
endmodule : parallel_unit_supervisor_test
